// [pss_regs.svh]
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

// device register locations (4-bit location select)
`define PSS_LOC_WIPER0   4'h0
`define PSS_LOC_WIPER1   4'h1
`define PSS_LOC_TERMINAL_CONNECT_CONTROL     4'h4
`define PSS_LOC_STATUS   4'h5

// device reset values
`define PSS_WIPER_RST    9'h080
`define PSS_TERMINAL_CONNECT_CONTROL_RST     9'h1ff

// command frame bit counts
`define PSS_OP_LAST_BIT  4'h5
`define PSS_BYTE_LAST    4'h7
`define PSS_WORD_LAST    4'hf

// controller register byte offsets
`define PSS_CTRL_OFS     4'h0
`define PSS_RXD_OFS      4'h4
`define PSS_IST_OFS      4'h8
`define PSS_IMASK_OFS    4'hc

// controller field positions
`define PSS_CTRL_LEN16   16
`define PSS_CTRL_MODE11  17
`define PSS_CTRL_HV      18
`define PSS_CTRL_GO      31
`define PSS_RXD_BUSY     16
`define PSS_IRQ_DONE     0
`define PSS_IRQ_ERR      1

// serial clock timing
`define PSS_CLK_NS       10
`define PSS_SCK_HALF_NS  50
`define PSS_SCK_HALF_CYC ((`PSS_SCK_HALF_NS + `PSS_CLK_NS - 1) / `PSS_CLK_NS)

`endif

// [pss_pkg.sv]
package pss_pkg;
  typedef enum logic [1:0]
  {
    PSS_OP_WRITE = 2'h0,
    PSS_OP_INC   = 2'h1,
    PSS_OP_DEC   = 2'h2,
    PSS_OP_READ  = 2'h3
  } pss_op_t;

  typedef enum logic [2:0]
  {
    PSS_H_IDLE,
    PSS_H_SETUP,
    PSS_H_LOW,
    PSS_H_HIGH,
    PSS_H_HOLD
  } pss_hstate_t;

  typedef logic [8:0] pss_word_t;
endpackage

// [pss_if.sv]
`timescale 1ns/1ps
interface pss_if;
  logic cs_n;
  logic high_voltage_select_level;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport device
  (
    input  cs_n,
    input  high_voltage_select_level,
    input  sck,
    input  mosi,
    output miso,
    output miso_oe
  );

  modport host
  (
    output cs_n,
    output high_voltage_select_level,
    output sck,
    output mosi,
    input  miso,
    input  miso_oe
  );
endinterface

// [pss_sync.sv]
`timescale 1ns/1ps
module pss_sync #(
  parameter int unsigned     W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [W-1:0]  d,
  output logic      [W-1:0]  q
);
  logic [W-1:0] meta_r;

  // two stages; only the second stage is visible to logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= RST;
      q      <= RST;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// [pss_device.sv]
`timescale 1ns/1ps
`include "pss_regs.svh"
// Functional notes
// - master frames commands by asserting chip select
// - select start drives output, clears bit count
// - invalid command gives low error bit
// - deselect resets logic, ignores clock and data
// - modes 0,0 and 1,1; rise samples, fall drives
// - serial clock at most 10 MHz
// - high-voltage select acts like normal select
// - command byte: location, opcode, two data bits
// - opcodes 11 read, 00 write, 01 inc, 10 dec
// - increment/decrement only on wiper locations
// - six ones, then error bit seventh
// - read returns data; others return ones
// - valid location/opcode pairs set error bit high
// - nine stored bits, tenth write bit dropped
// - partial commands ignored; write needs sixteen clocks
// - after error ignore commands, output low
// - write joins upper bit with data byte
// - mode taken from clock level at select
module pss_device (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  pss_if.device             link,
  input  wire pss_pkg::pss_word_t status_in,
  output pss_pkg::pss_word_t      wiper0_position,
  output pss_pkg::pss_word_t      wiper1_position,
  output pss_pkg::pss_word_t      terminal_connect_control,
  output logic              mode11,
  output logic              cmd_error
);
  import pss_pkg::*;

  logic       cs_n_s;
  logic       hv_s;
  logic       sck_s;
  logic       mosi_s;
  logic       sel;
  logic       sel_d_r;
  logic       sck_d_r;
  logic       start;
  logic       rise;
  logic       fall;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] nb;
  logic [3:0] location_select_field_r;
  pss_op_t    operation_code_field_r;
  logic       upper_data_bit_r;
  logic       err_r;
  logic       miso_r;
  logic       miso_oe_r;
  logic       exec_inc;
  logic       exec_dec;
  logic       exec_wr;
  pss_word_t  rdat;
  pss_word_t  wdat;
  logic       out_bit;

  // pins cross into aclk before any edge detection
  pss_sync #(
    .W   (4),
    .RST (4'h8)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({link.cs_n, link.high_voltage_select_level, link.sck, link.mosi}),
    .q       ({cs_n_s, hv_s, sck_s, mosi_s})
  );

  // high-voltage select is just another active level
  assign sel = !cs_n_s || hv_s;
  assign start = sel && !sel_d_r;
  assign rise  = sel && sck_s && !sck_d_r;
  assign fall  = sel && !sck_s && sck_d_r;
  assign nb    = {sh_r[6:0], mosi_s};

  // which location/opcode pairs are legal
  function automatic logic pair_ok(input logic [3:0] loc, input pss_op_t op);
    if (loc == `PSS_LOC_WIPER0 || loc == `PSS_LOC_WIPER1)
      pair_ok = 1'b1;
    else if (loc == `PSS_LOC_TERMINAL_CONNECT_CONTROL)
      pair_ok = (op == PSS_OP_READ) || (op == PSS_OP_WRITE);
    else if (loc == `PSS_LOC_STATUS)
      pair_ok = (op == PSS_OP_READ);
    else
      pair_ok = 1'b0;
  endfunction

  // read mux over the nine-bit map
  function automatic pss_word_t map_rd(input logic [3:0] loc, input pss_word_t w0,
                                       input pss_word_t w1, input pss_word_t tc,
                                       input pss_word_t st);
    if (loc == `PSS_LOC_WIPER0)
      map_rd = w0;
    else if (loc == `PSS_LOC_WIPER1)
      map_rd = w1;
    else if (loc == `PSS_LOC_TERMINAL_CONNECT_CONTROL)
      map_rd = tc;
    else if (loc == `PSS_LOC_STATUS)
      map_rd = st;
    else
      map_rd = '0;
  endfunction

  // edge history of the synchronised pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_d_r <= 1'b0;
      sck_d_r <= 1'b0;
    end
    else
    begin
      sel_d_r <= sel;
      sck_d_r <= sck_s;
    end
  end

  // mode is whatever the clock idles at when selected
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode11 <= 1'b0;
    else if (start)
      mode11 <= sck_s;
  end

  // bit counter and input shifter; nothing moves while deselected
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sel || start)
    begin
      cnt_r <= 4'h0;
      sh_r  <= 8'h00;
    end
    else if (rise && !err_r)
    begin
      sh_r <= nb;
      if (cnt_r == `PSS_BYTE_LAST && operation_code_field_r != PSS_OP_READ
          && operation_code_field_r != PSS_OP_WRITE)
        cnt_r <= 4'h0;
      else
        cnt_r <= cnt_r + 4'h1;
    end
  end

  // command byte fields captured as they complete
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sel)
    begin
      location_select_field_r <= 4'h0;
      operation_code_field_r  <= PSS_OP_WRITE;
      upper_data_bit_r        <= 1'b0;
    end
    else if (rise && !err_r)
    begin
      if (cnt_r == `PSS_OP_LAST_BIT)
      begin
        location_select_field_r <= nb[5:2];
        operation_code_field_r  <= pss_op_t'(nb[1:0]);
      end
      if (cnt_r == `PSS_BYTE_LAST)
        upper_data_bit_r <= mosi_s;
    end
  end

  // error latch: only deselect clears it
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sel)
      err_r <= 1'b0;
    else if (rise && !err_r && cnt_r == `PSS_OP_LAST_BIT)
      err_r <= !pair_ok(nb[5:2], pss_op_t'(nb[1:0]));
  end

  // commands act only on their last clock, so partial frames do nothing
  always_comb
  begin
    exec_inc = rise && !err_r && cnt_r == `PSS_BYTE_LAST
               && operation_code_field_r == PSS_OP_INC;
    exec_dec = rise && !err_r && cnt_r == `PSS_BYTE_LAST
               && operation_code_field_r == PSS_OP_DEC;
    exec_wr  = rise && !err_r && cnt_r == `PSS_WORD_LAST
               && operation_code_field_r == PSS_OP_WRITE;
    wdat     = {upper_data_bit_r, nb};
  end

  // wiper registers; saturation limits are not modelled, counts wrap
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wiper0_position <= `PSS_WIPER_RST;
      wiper1_position <= `PSS_WIPER_RST;
    end
    else if (location_select_field_r == `PSS_LOC_WIPER0)
    begin
      if (exec_wr)
        wiper0_position <= wdat;
      else if (exec_inc)
        wiper0_position <= wiper0_position + 9'h001;
      else if (exec_dec)
        wiper0_position <= wiper0_position - 9'h001;
    end
    else if (location_select_field_r == `PSS_LOC_WIPER1)
    begin
      if (exec_wr)
        wiper1_position <= wdat;
      else if (exec_inc)
        wiper1_position <= wiper1_position + 9'h001;
      else if (exec_dec)
        wiper1_position <= wiper1_position - 9'h001;
    end
  end

  // terminal control register, written only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      terminal_connect_control <= `PSS_TERMINAL_CONNECT_CONTROL_RST;
    else if (exec_wr && location_select_field_r == `PSS_LOC_TERMINAL_CONNECT_CONTROL)
      terminal_connect_control <= wdat;
  end

  // next output bit by position: ones, error bit, then read data
  always_comb
  begin
    rdat = map_rd(location_select_field_r, wiper0_position, wiper1_position,
                  terminal_connect_control, status_in);
    if (err_r)
      out_bit = 1'b0;
    else if (cnt_r <= 4'h6)
      out_bit = 1'b1;
    else if (operation_code_field_r != PSS_OP_READ)
      out_bit = 1'b1;
    else if (cnt_r == `PSS_BYTE_LAST)
      out_bit = rdat[8];
    else
      out_bit = rdat[3'(~cnt_r[2:0])];
  end

  // while selected, output changes only on falling clock edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sel)
      miso_r <= 1'b1;
    else if (start)
      miso_r <= 1'b1;
    else if (fall)
      miso_r <= out_bit;
  end

  // drive the pin for the whole select window
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      miso_oe_r <= 1'b0;
    else
      miso_oe_r <= sel;
  end

  assign link.miso    = miso_r;
  assign link.miso_oe = miso_oe_r;
  assign cmd_error    = err_r;
endmodule

// [pss_host.sv]
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pss_regs.svh"
module pss_host #(
  parameter int unsigned HALF = `PSS_SCK_HALF_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  pss_if.host              link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  import pss_pkg::*;

  logic [31:0] ctrl_r;
  logic [15:0] rx_r;
  logic [15:0] tx_r;
  logic [1:0]  ist_r;
  logic [1:0]  imask_r;
  logic [3:0]  awa_r;
  logic [31:0] wd_r;
  logic        aw_h_r;
  logic        w_h_r;
  logic        go;
  logic        wr_do;
  logic [15:0] div_r;
  logic [4:0]  bit_r;
  logic        done;
  logic        miso_s;
  pss_hstate_t st_r;

  assign wr_do = aw_h_r && w_h_r && !s_axi_bvalid;
  assign go    = wr_do && awa_r == `PSS_CTRL_OFS && wd_r[`PSS_CTRL_GO];

  pss_sync #(
    .W   (1),
    .RST (1'b1)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (link.miso),
    .q       (miso_s)
  );

  // address and data are taken independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_h_r <= 1'b0;
      w_h_r  <= 1'b0;
      awa_r  <= 4'h0;
      wd_r   <= 32'h0;
    end
    else if (wr_do)
    begin
      aw_h_r <= 1'b0;
      w_h_r  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_h_r <= 1'b1;
        awa_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_h_r <= 1'b1;
        wd_r  <= s_axi_wdata;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_h_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_h_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_do)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awa_r[1:0] != 2'h0 || awa_r == `PSS_RXD_OFS) ? 2'h2 : 2'h0;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // software registers; a command start is ignored while busy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r  <= 32'h0;
      imask_r <= 2'h0;
    end
    else if (wr_do && awa_r == `PSS_CTRL_OFS && st_r == PSS_H_IDLE)
      ctrl_r <= {1'b0, wd_r[30:0]};
    else if (wr_do && awa_r == `PSS_IMASK_OFS)
      imask_r <= wd_r[1:0];
  end

  // sticky events: a new event wins over a write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ist_r <= 2'h0;
    else
      ist_r <= (ist_r & ~((wr_do && awa_r == `PSS_IST_OFS) ? wd_r[1:0] : 2'h0))
               | {done && !rx_r[ctrl_r[`PSS_CTRL_LEN16] ? 9 : 1], done};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(ist_r & imask_r);
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        if (s_axi_araddr == `PSS_CTRL_OFS)
          s_axi_rdata <= ctrl_r;
        else if (s_axi_araddr == `PSS_RXD_OFS)
          s_axi_rdata <= {15'h0, st_r != PSS_H_IDLE, rx_r};
        else if (s_axi_araddr == `PSS_IST_OFS)
          s_axi_rdata <= {30'h0, ist_r};
        else if (s_axi_araddr == `PSS_IMASK_OFS)
          s_axi_rdata <= {30'h0, imask_r};
        else
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // serial engine: half-period divider, sample late in the high phase
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r  <= PSS_H_IDLE;
      div_r <= 16'h0;
      bit_r <= 5'h0;
      tx_r  <= 16'h0;
      rx_r  <= 16'h0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (st_r == PSS_H_IDLE)
      begin
        if (go)
        begin
          st_r  <= PSS_H_SETUP;
          tx_r  <= {wd_r[7:0], wd_r[15:8]}; // low byte is always the command byte
          bit_r <= wd_r[`PSS_CTRL_LEN16] ? 5'h10 : 5'h08;
          div_r <= 16'(HALF - 1);
        end
      end
      else if (div_r != 16'h0)
        div_r <= div_r - 16'h1;
      else
      begin
        div_r <= 16'(HALF - 1);
        case (st_r)
          PSS_H_SETUP: st_r <= PSS_H_LOW;
          PSS_H_LOW:   st_r <= PSS_H_HIGH;
          PSS_H_HIGH:
          begin
            rx_r  <= {rx_r[14:0], miso_s};
            tx_r  <= {tx_r[14:0], 1'b0};
            bit_r <= bit_r - 5'h1;
            st_r  <= (bit_r == 5'h1) ? PSS_H_HOLD : PSS_H_LOW;
          end
          PSS_H_HOLD:
          begin
            st_r <= PSS_H_IDLE;
            done <= 1'b1;
          end
          default: st_r <= PSS_H_IDLE;
        endcase
      end
    end
  end

  // pin registers; clock idles at the chosen mode level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link.cs_n <= 1'b1;
      link.sck  <= 1'b0;
      link.mosi <= 1'b1;
      link.high_voltage_select_level <= 1'b0;
    end
    else
    begin
      // the two select levels exclude each other, as on a real pin
      link.cs_n <= (st_r == PSS_H_IDLE) || ctrl_r[`PSS_CTRL_HV];
      link.high_voltage_select_level <= (st_r != PSS_H_IDLE) && ctrl_r[`PSS_CTRL_HV];
      link.mosi <= (st_r == PSS_H_IDLE) ? 1'b1 : tx_r[15];
      if (st_r == PSS_H_LOW)
        link.sck <= 1'b0;
      else if (st_r == PSS_H_HIGH)
        link.sck <= 1'b1;
      else if (go && st_r == PSS_H_IDLE)
        link.sck <= wd_r[`PSS_CTRL_MODE11]; // settle idle level a cycle before select
      else
        link.sck <= ctrl_r[`PSS_CTRL_MODE11];
    end
  end
endmodule

// [pss_link_asserts.sv]
`timescale 1ns/1ps
module pss_link_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic high_voltage_select_level,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic       sel;
  logic       sck_q_r;
  logic [3:0] hold_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // either select level counts as selected
  assign sel = !cs_n || high_voltage_select_level;

  // cycles the serial clock stood still; saturates so long idle gaps stay harmless
  always_ff @(posedge aclk)
  begin
    sck_q_r <= sck;
    if (!aresetn)
      hold_r <= 4'hf;
    else if (sck != sck_q_r)
      hold_r <= 4'h0;
    else if (hold_r != 4'hf)
      hold_r <= hold_r + 4'h1;
  end

  property p_oe_on;
    $rose(sel) |-> ##[1:8] miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven after select");

  property p_oe_hold;
    sel [*6] |-> miso_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("output dropped while selected");

  property p_oe_off;
    $fell(sel) |-> ##[1:8] !miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output still driven after deselect");

  property p_first_one;
    $rose(miso_oe) |-> miso;
  endproperty
  a_first_one: assert property (p_first_one) else $error("first output bit not one");

  // sync delay keeps the update well inside the low half of the clock
  property p_miso_fall;
    sel && miso_oe && $past(miso_oe) && $changed(miso) |-> !sck;
  endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("output moved with clock high");

  property p_mosi_setup;
    $rose(sck) && sel |-> mosi == $past(mosi) && mosi == $past(mosi, 2);
  endproperty
  a_mosi_setup: assert property (p_mosi_setup) else $error("data moved at clock rise");

  property p_sck_half;
    sck != sck_q_r |-> hold_r >= 4'h4;
  endproperty
  a_sck_half: assert property (p_sck_half) else $error("serial clock half too short");

  property p_cs_setup;
    $rose(sel) |-> ##1 $stable(sck) [*4];
  endproperty
  a_cs_setup: assert property (p_cs_setup) else $error("clock edge too soon after select");
endmodule

// [pot_spi_command_slave_test.sv]
`timescale 1ns/1ps
module pot_spi_command_slave_test;
  import pss_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [3:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        irq;
  pss_word_t   status_in;
  pss_word_t   wiper0;
  pss_word_t   wiper1;
  pss_word_t   tcc;
  logic        mode11;
  logic        cmd_error;
  int          num_errors;
  int          n_checks;
  int          cycles;
  logic [31:0] rd;
  logic [1:0]  resp;
  logic        err_seen;

  pss_if pss_if_i ();

  pss_host pss_host_i (
    .aclk(aclk), .aresetn(aresetn), .link(pss_if_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq)
  );

  pss_device pss_device_i (
    .aclk(aclk), .aresetn(aresetn), .link(pss_if_i), .status_in(status_in),
    .wiper0_position(wiper0), .wiper1_position(wiper1),
    .terminal_connect_control(tcc), .mode11(mode11), .cmd_error(cmd_error)
  );

  pss_link_asserts pss_link_asserts_i (
    .aclk(aclk), .aresetn(aresetn), .cs_n(pss_if_i.cs_n),
    .high_voltage_select_level(pss_if_i.high_voltage_select_level),
    .sck(pss_if_i.sck), .mosi(pss_if_i.mosi), .miso(pss_if_i.miso),
    .miso_oe(pss_if_i.miso_oe)
  );

  // free-running system clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // hang guard: a whole run needs a few thousand cycles
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end

  // remember that the device latched an error somewhere inside a frame
  always @(posedge aclk)
  begin
    if (cmd_error === 1'b1)
      err_seen <= 1'b1;
  end

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask

  task rdw(input logic [3:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    rd   = rdata;
    resp = rresp;
  endtask

  // start one frame and poll busy; the received bits end up in rd
  task frm(input logic [31:0] ctrl);
    wr(4'h0, ctrl | 32'h8000_0000);
    rdw(4'h4);
    while (rd[16] === 1'b1)
      rdw(4'h4);
  endtask

  task t_write_read;
    chk({wiper0, wiper1, tcc}, {9'h080, 9'h080, 9'h1ff});
    frm(32'h0001_a503);
    chk(wiper0, 9'h1a5);
    chk(rd[15:0], 16'hffff);
    frm(32'h0001_000c);
    chk(rd[15:0], 16'hffa5);
    chk(mode11, 1'b0);
  endtask

  task t_inc_dec;
    frm(32'h0000_0014);
    chk(wiper1, 9'h081);
    chk(rd[7:0], 8'hff);
    repeat (2) frm(32'h0006_0018);
    chk(wiper1, 9'h07f);
    chk(mode11, 1'b1);
    frm(32'h0004_0004);
    chk(wiper0, 9'h1a6);
  endtask

  task t_map;
    frm(32'h0001_1242);
    chk(tcc, 9'h012);
    frm(32'h0003_004c);
    chk(rd[15:0], 16'hfe12);
    frm(32'h0001_005c);
    chk(rd[15:0], 16'hff2d);
  endtask

  // bad pairs: error bit low on the seventh bit, all later bits low
  task t_errors;
    logic [31:0] bad [4];
    bad = '{32'h0000_0044, 32'h0001_ff53, 32'h0001_002c, 32'h0000_0058};
    chk(err_seen, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      frm(bad[i]);
      chk(bad[i][16] ? rd[15:0] : {rd[7:0], 8'h00}, 16'hfc00);
      repeat (4) @(posedge aclk);
      chk(cmd_error, 1'b0);
    end
    chk(err_seen, 1'b1);
    chk({wiper0, tcc}, {9'h1a6, 9'h012});
  endtask

  // a set mask bit lets its status bit through to the interrupt line
  task t_irq;
    logic a;
    rdw(4'h8);
    chk(rd[1:0], 2'h3);
    wr(4'hc, 32'h0);
    repeat (2) @(posedge aclk);
    a = irq;
    wr(4'hc, 32'h3);
    repeat (2) @(posedge aclk);
    chk({a, irq}, 2'h1);
    wr(4'h8, 32'h3);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    rdw(4'h8);
    chk(rd[1:0], 2'h0);
    wr(4'h4, 32'h0);
    chk(resp, 2'h2);
    rdw(4'h2);
    chk({resp, rd[29:0]}, 32'h8000_0000);
  endtask

  initial
  begin
    aresetn    = 1'b0;
    awaddr     = 4'h0;
    awvalid    = 1'b0;
    wdata      = 32'h0;
    wvalid     = 1'b0;
    bready     = 1'b0;
    araddr     = 4'h0;
    arvalid    = 1'b0;
    rready     = 1'b0;
    status_in  = 9'h12d;
    num_errors = 0;
    n_checks   = 0;
    cycles     = 0;
    err_seen   = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_write_read;
    t_inc_dec;
    t_map;
    t_errors;
    t_irq;
    end_sim;
  end
endmodule
